// File: hw/audio_port_clock_role_and_channel_enable.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module audio_port_clock_role_and_channel_enable (
    // Clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    // Write address and data
    input  wire logic [31:0]                    awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    // Write response
    output logic [1:0]                          bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    // Read
    input  wire logic [31:0]                    araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    output logic [31:0]                         rdata,
    output logic [1:0]                          rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    // Port pins, index 0 is port 1
    input  wire audio_port_pkg::port_pins_s [1:0] pin_in,
    output wire audio_port_pkg::port_pins_s [1:0] pin_out,
    output wire audio_port_pkg::port_pins_s [1:0] pin_oe
);
    logic [31:0] chan_en [2];
    logic [31:0] ctrl [2];
    logic [31:0] clk_cfg;
    logic        refused;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wport;
    logic [31:0] cand;
    logic [5:0]  cnt_total;
    logic        refuse;
    logic        en_write;
    logic [31:0] rd_val;
    audio_port_pkg::reg_sel_e wsel;
    audio_port_pkg::reg_sel_e rsel;
    wire  [3:0]  port_state [2];
    wire  [1:0]  bclk_run;
    wire  [1:0]  fs_run;

    function automatic audio_port_pkg::reg_sel_e sel_of(
        input logic [31:0] a);
        if (a == audio_port_pkg::PORT1_EN_ADDR) begin
            return audio_port_pkg::SEL_P1_EN;
        end else if (a == audio_port_pkg::PORT1_CTRL_ADDR) begin
            return audio_port_pkg::SEL_P1_CTRL;
        end else if (a == audio_port_pkg::PORT2_EN_ADDR) begin
            return audio_port_pkg::SEL_P2_EN;
        end else if (a == audio_port_pkg::PORT2_CTRL_ADDR) begin
            return audio_port_pkg::SEL_P2_CTRL;
        end else if (a == audio_port_pkg::CLK_CFG_ADDR) begin
            return audio_port_pkg::SEL_CLK_CFG;
        end else if (a == audio_port_pkg::STATUS_ADDR) begin
            return audio_port_pkg::SEL_STATUS;
        end else begin
            return audio_port_pkg::SEL_NONE;
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] ones(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction

    // Write channel capture
    assign do_write = aw_held && w_held && !bvalid;
    assign wsel = sel_of(aw_addr);
    assign rsel = sel_of(araddr);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
            aw_addr <= 32'h0000_0000;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr;
        end else if (bvalid && bready) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            wready <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (bvalid && bready) begin
            w_held <= 1'b0;
            wready <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= audio_port_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (wsel == audio_port_pkg::SEL_NONE) ?
                      audio_port_pkg::RESP_SLVERR :
                      audio_port_pkg::RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Enable check against the clock's path capacity
    always_comb begin
        wport = (wsel == audio_port_pkg::SEL_P2_EN);
        cand = merge(chan_en[wport], w_data, w_strb) &
               (wport ? audio_port_pkg::PORT2_EN_MASK :
                        audio_port_pkg::PORT1_EN_MASK);
        cnt_total = ones(cand) + ones(chan_en[!wport]);
        refuse = (|(cand & ~chan_en[wport])) &&
                 (!clk_cfg[audio_port_pkg::CLK_ON_BIT] ||
                  cnt_total > {1'b0, clk_cfg[audio_port_pkg::CAP_MSB:
                                             audio_port_pkg::CAP_LSB]});
        en_write = do_write && (wsel == audio_port_pkg::SEL_P1_EN ||
                                wsel == audio_port_pkg::SEL_P2_EN);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_en[0] <= audio_port_pkg::RESET_VALUE;
            chan_en[1] <= audio_port_pkg::RESET_VALUE;
            ctrl[0]    <= audio_port_pkg::RESET_VALUE;
            ctrl[1]    <= audio_port_pkg::RESET_VALUE;
            clk_cfg    <= audio_port_pkg::RESET_VALUE;
        end else if (en_write) begin
            // Refused: new bits dropped, running ones kept unless this write clears them
            chan_en[wport] <= refuse ? (cand & chan_en[wport])
                                     : cand;
        end else if (do_write) begin
            case (wsel)
                audio_port_pkg::SEL_P1_CTRL: begin
                    ctrl[0] <= merge(ctrl[0], w_data, w_strb) &
                               audio_port_pkg::CTRL_MASK;
                end
                audio_port_pkg::SEL_P2_CTRL: begin
                    ctrl[1] <= merge(ctrl[1], w_data, w_strb) &
                               audio_port_pkg::CTRL_MASK;
                end
                audio_port_pkg::SEL_CLK_CFG: begin
                    clk_cfg <= merge(clk_cfg, w_data, w_strb) &
                               audio_port_pkg::CLK_CFG_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky refusal flag, write one to clear, set wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (en_write && refuse) begin
            refused <= 1'b1;
        end else if (do_write && wsel == audio_port_pkg::SEL_STATUS &&
                     w_strb[0] && w_data[0]) begin
            refused <= 1'b0;
        end
    end

    // Read channel
    always_comb begin
        case (rsel)
            audio_port_pkg::SEL_P1_EN:   rd_val = chan_en[0];
            audio_port_pkg::SEL_P1_CTRL: rd_val = ctrl[0];
            audio_port_pkg::SEL_P2_EN:   rd_val = chan_en[1];
            audio_port_pkg::SEL_P2_CTRL: rd_val = ctrl[1];
            audio_port_pkg::SEL_CLK_CFG: rd_val = clk_cfg;
            audio_port_pkg::SEL_STATUS:  rd_val = {23'h000000,
                port_state[1], port_state[0], refused};
            default:                     rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= audio_port_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= (rsel == audio_port_pkg::SEL_NONE) ?
                       audio_port_pkg::RESP_SLVERR :
                       audio_port_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // Per-port clock roles
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [2:0] bclk_sync;
        logic [2:0] fs_sync;
        logic       bclk_lvl;
        logic       fs_lvl;
        logic [7:0] div_cnt;
        logic [5:0] bit_cnt;
        logic       int_bclk;
        logic       fs_level;
        logic       bclk_o;
        logic       bclk_oe;
        logic       fs_o;
        logic       fs_oe;
        wire        drv   = ctrl[p][audio_port_pkg::BCLK_DRIVE_BIT];
        wire        fdrv  = ctrl[p][audio_port_pkg::FRAME_SYNC_DRIVE_BIT];
        wire        inv   = ctrl[p][audio_port_pkg::BCLK_INV_BIT];
        wire        finv  = ctrl[p][audio_port_pkg::FRAME_SYNC_INV_BIT];
        wire        any_en = |chan_en[p];
        wire        ext_rise;
        wire        int_rise;
        wire        bit_edge;

        // Roles are independent per pin
        assign bclk_run[p] = drv && (any_en ||
            ctrl[p][audio_port_pkg::BCLK_FORCE_BIT]);
        assign fs_run[p] = fdrv && (any_en ||
            ctrl[p][audio_port_pkg::FRAME_SYNC_FORCE_BIT]);

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                bclk_sync <= 3'h0;
                fs_sync   <= 3'h0;
                bclk_lvl  <= 1'b0;
                fs_lvl    <= 1'b0;
            end else begin
                bclk_sync <= {bclk_sync[1:0], pin_in[p].bclk};
                fs_sync   <= {fs_sync[1:0], pin_in[p].frame_sync};
                if (bclk_sync[2] == bclk_sync[1]) begin
                    bclk_lvl <= bclk_sync[2];
                end
                if (fs_sync[2] == fs_sync[1]) begin
                    fs_lvl <= fs_sync[2];
                end
            end
        end

        // Received edge, after the polarity choice
        assign ext_rise = (bclk_sync[2] == bclk_sync[1]) &&
            (bclk_sync[2] ^ inv) && !(bclk_lvl ^ inv);

        // Master divider, half rate of mclk at most
        always_ff @(posedge mclk) begin
            if (!rst_n || !bclk_run[p]) begin
                div_cnt  <= 8'h00;
                int_bclk <= 1'b0;
            end else if (div_cnt == audio_port_pkg::BCLK_HALF_CYCLES
                                    - 8'h01) begin
                div_cnt  <= 8'h00;
                int_bclk <= !int_bclk;
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end

        assign int_rise = bclk_run[p] && !int_bclk &&
            div_cnt == audio_port_pkg::BCLK_HALF_CYCLES - 8'h01;
        assign bit_edge = drv ? int_rise : ext_rise;

        // Frame sync from bit clock count
        always_ff @(posedge mclk) begin
            if (!rst_n || !fs_run[p]) begin
                bit_cnt  <= 6'h00;
                fs_level <= 1'b0;
            end else if (bit_edge) begin
                bit_cnt  <= bit_cnt + 6'h01;
                fs_level <= (bit_cnt == audio_port_pkg::FRAME_LAST);
            end
        end

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                bclk_o  <= 1'b0;
                bclk_oe <= 1'b0;
                fs_o    <= 1'b0;
                fs_oe   <= 1'b0;
            end else begin
                bclk_o  <= int_bclk ^ inv;
                bclk_oe <= drv;
                fs_o    <= fs_level ^ finv;
                fs_oe   <= fdrv;
            end
        end

        assign pin_out[p] = {bclk_o, fs_o};
        assign pin_oe[p]  = {bclk_oe, fs_oe};
        assign port_state[p] = {fdrv ? fs_level : fs_lvl ^ finv,
                                drv ? int_bclk : bclk_lvl ^ inv,
                                fs_oe, bclk_oe};
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_bclk_role;
        1'b1 |=> pin_oe[0].bclk ==
                 $past(ctrl[0][audio_port_pkg::BCLK_DRIVE_BIT]);
    endproperty
    a_bclk_role: assert property (p_bclk_role)
        else $error("bit clock enable does not follow role");

    property p_fs_role;
        1'b1 |=> pin_oe[1].frame_sync ==
                 $past(ctrl[1][audio_port_pkg::FRAME_SYNC_DRIVE_BIT]);
    endproperty
    a_fs_role: assert property (p_fs_role)
        else $error("frame sync enable does not follow role");

    property p_mixed;
        !ctrl[0][audio_port_pkg::BCLK_DRIVE_BIT] &&
            ctrl[0][audio_port_pkg::FRAME_SYNC_DRIVE_BIT] |=>
            !pin_oe[0].bclk && pin_oe[0].frame_sync;
    endproperty
    a_mixed: assert property (p_mixed)
        else $error("mixed role not honoured");

    property p_bclk_idle;
        (!bclk_run[0])[*3] |-> pin_out[0].bclk ==
            $past(ctrl[0][audio_port_pkg::BCLK_INV_BIT]);
    endproperty
    a_bclk_idle: assert property (p_bclk_idle)
        else $error("bit clock moves while stopped");

    property p_bclk_runs;
        $rose(bclk_run[0]) ##1 bclk_run[0][*8] |->
            ##[1:6] $changed(pin_out[0].bclk);
    endproperty
    a_bclk_runs: assert property (p_bclk_runs)
        else $error("running bit clock does not toggle");

    property p_fs_idle;
        (!fs_run[1])[*3] |-> pin_out[1].frame_sync ==
            $past(ctrl[1][audio_port_pkg::FRAME_SYNC_INV_BIT]);
    endproperty
    a_fs_idle: assert property (p_fs_idle)
        else $error("frame sync level or polarity wrong");

    property p_fs_from_bclk;
        fs_run[0] && $past(fs_run[0]) && $changed(g_port[0].bit_cnt)
            |-> $past(g_port[0].bit_edge);
    endproperty
    a_fs_from_bclk: assert property (p_fs_from_bclk)
        else $error("frame count moved without a bit clock edge");

    property p_refuse;
        en_write && refuse |=> refused &&
            ((($past(wport) ? chan_en[1] : chan_en[0]) &
              ~$past(chan_en[wport])) == 32'h0000_0000);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused enable took effect");

    property p_keep;
        en_write && refuse && !wport |=>
            chan_en[0] == ($past(cand) & $past(chan_en[0]));
    endproperty
    a_keep: assert property (p_keep)
        else $error("refusal disturbed running channels");

    property p_mask2;
        (chan_en[1] & ~audio_port_pkg::PORT2_EN_MASK) == 32'h0000_0000;
    endproperty
    a_mask2: assert property (p_mask2)
        else $error("port 2 enable outside its fields");

    property p_reset;
        $rose(rst_n) |-> chan_en[0] == 32'h0000_0000 &&
            ctrl[1] == 32'h0000_0000;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state not cleared by reset");

    c_refused: cover property (en_write && refuse);
    c_forced: cover property (bclk_run[0] && chan_en[0] == 32'h0);
    c_frame: cover property ($rose(pin_out[0].frame_sync));
    c_slave_edge: cover property (g_port[1].ext_rise);
endmodule
`default_nettype wire

// File: hw/audio_port_pkg.sv
package audio_port_pkg;
    // Register byte addresses
    localparam logic [31:0] PORT1_EN_ADDR   = 32'h0000_6000;
    localparam logic [31:0] PORT1_CTRL_ADDR = 32'h0000_6008;
    localparam logic [31:0] PORT2_EN_ADDR   = 32'h0000_6080;
    localparam logic [31:0] PORT2_CTRL_ADDR = 32'h0000_6088;
    localparam logic [31:0] CLK_CFG_ADDR    = 32'h0000_6100;
    localparam logic [31:0] STATUS_ADDR     = 32'h0000_6104;
    // Control fields
    localparam int FRAME_SYNC_DRIVE_BIT = 0;
    localparam int FRAME_SYNC_FORCE_BIT = 1;
    localparam int FRAME_SYNC_INV_BIT   = 2;
    localparam int BCLK_DRIVE_BIT  = 4;
    localparam int BCLK_FORCE_BIT  = 5;
    localparam int BCLK_INV_BIT    = 6;
    localparam logic [31:0] CTRL_MASK     = 32'h0000_0077;
    localparam logic [31:0] PORT1_EN_MASK = 32'h00ff_00ff;
    localparam logic [31:0] PORT2_EN_MASK = 32'h000f_000f;
    // Clock config: bit 0 clock on, bits 12:8 path capacity
    localparam int CLK_ON_BIT = 0;
    localparam int CAP_LSB    = 8;
    localparam int CAP_MSB    = 12;
    localparam logic [31:0] CLK_CFG_MASK = 32'h0000_1f01;
    localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
    // Timing
    localparam int MCLK_HZ        = 50_000_000;
    localparam int BCLK_MASTER_HZ = 12_288_000;
    localparam logic [7:0] BCLK_HALF_CYCLES =
        8'(MCLK_HZ / (2 * BCLK_MASTER_HZ));
    localparam logic [5:0] FRAME_LAST = 6'h3f;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_P1_EN, SEL_P1_CTRL, SEL_P2_EN,
        SEL_P2_CTRL, SEL_CLK_CFG, SEL_STATUS
    } reg_sel_e;

    typedef struct packed {
        logic bclk;
        logic frame_sync;
    } port_pins_s;
endpackage

// File: tb/far_end_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
    // Far side run control
    input  wire logic [1:0]                       run,
    // Device pins
    input  wire audio_port_pkg::port_pins_s [1:0] pin_out,
    input  wire audio_port_pkg::port_pins_s [1:0] pin_oe,
    output wire audio_port_pkg::port_pins_s [1:0] pin_in
);
    logic [1:0] bclk_far;
    logic [1:0] frame_sync_far;
    int         bits [2];

    // Far bit clock of 160 ns, frame sync every 64 bits
    initial begin
        bclk_far = 2'h0;
        frame_sync_far = 2'h0;
        bits = '{0, 0};
        #7;
        forever begin
            #80;
            for (int p = 0; p < 2; p++) begin
                if (run[p]) begin
                    bclk_far[p] = ~bclk_far[p];
                    if (bclk_far[p]) begin
                        bits[p] = (bits[p] + 1) % 64;
                        frame_sync_far[p] = (bits[p] == 0);
                    end
                end
            end
        end
    end

    // Wire level from whoever drives
    for (genvar p = 0; p < 2; p++) begin : g_wire
        assign pin_in[p].bclk  = pin_oe[p].bclk ? pin_out[p].bclk
                                                : bclk_far[p];
        assign pin_in[p].frame_sync = pin_oe[p].frame_sync ? pin_out[p].frame_sync
                                                 : frame_sync_far[p];
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [1:0]  run = 2'h0;
    logic [31:0] mreg [5] = '{default: 32'h0};
    logic [31:0] addrs [5] = '{32'h6000, 32'h6008, 32'h6080, 32'h6088,
                               32'h6100};
    int          miscompares = 0;
    int          checked = 0;
    integer      seed = 91790;
    wire audio_port_pkg::port_pins_s [1:0] pin_in, pin_out, pin_oe;

    always #10 mclk = ~mclk;

    audio_port_clock_role_and_channel_enable
        u_audio_port_clock_role_and_channel_enable (
        .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

    far_end_model u_far_end_model (
        .run(run), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    task automatic give_verdict();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input bit w, input logic [31:0] a, d,
                        output logic [31:0] q, output logic [1:0] r);
        bit   done;
        logic ha, hw, hv;
        done = 1'b0;
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int n = 0; n < 200 && !done; n++) begin
            @(negedge mclk);
            ha = w ? awready : arready;
            hw = wready;
            hv = w ? bvalid : rvalid;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge mclk);
            if (w && ha) awvalid <= 1'b0;
            if (w && hw) wvalid <= 1'b0;
            if (w && hv) bready <= 1'b0;
            if (!w && ha) arvalid <= 1'b0;
            if (!w && hv) rready <= 1'b0;
            done = hv;
        end
        if (!done) begin
            miscompares++;
            give_verdict();
        end else begin
            @(posedge mclk);
        end
    endtask

    task automatic put(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q, n, sm;
        logic [1:0]  r;
        int          i;
        i = -1;
        for (int k = 0; k < 5; k++) if (addrs[k] == a) i = k;
        xfer(1'b1, a, d, q, r);
        sm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
        if (i >= 0) d = (d & sm) | (mreg[i] & ~sm);
        n = d & (i == 0 ? 32'h00ff00ff : 32'h000f000f);
        if ((i == 0 || i == 2) && (n & ~mreg[i]) != 0 && (!mreg[4][0] ||
            $countones(n) + $countones(mreg[2 - i]) > mreg[4][12:8]))
            n = n & mreg[i];
        if (i == 0 || i == 2) mreg[i] = n;
        if (i == 1 || i == 3) mreg[i] = d & 32'h77;
        if (i == 4) mreg[i] = d & 32'h1f01;
        chk({30'h0, r}, i < 0 ? 32'h2 : 32'h0);
        xfer(1'b0, a, 32'h0, q, r);
        chk(q, i < 0 ? 32'h0 : mreg[i]);
        chk({30'h0, r}, i < 0 ? 32'h2 : 32'h0);
    endtask

    task automatic pins(input int p, input logic [8:0] c);
        logic clk, fs, b0, f0;
        int   nb, nf, hi;
        put(addrs[2 * p], 32'h0);
        put(addrs[2 * p + 1], {25'h0, c[6:0]});
        put(addrs[2 * p], {31'h0, c[7]});
        run[p] <= c[8];
        clk = c[4] && (c[7] || c[5]);
        fs = c[0] && (c[7] || c[1]) && (c[4] ? clk : c[8]);
        nb = 0;
        nf = 0;
        hi = 0;
        @(negedge mclk);
        b0 = pin_out[p].bclk;
        f0 = pin_out[p].frame_sync;
        for (int i = 0; i < 1100; i++) begin
            @(negedge mclk);
            nb += int'(pin_out[p].bclk !== b0);
            nf += int'(pin_out[p].frame_sync !== f0);
            hi += int'(pin_out[p].frame_sync === 1'b1);
            b0 = pin_out[p].bclk;
            f0 = pin_out[p].frame_sync;
        end
        @(posedge mclk);
        run[p] <= 1'b0;
        chk({30'h0, pin_oe[p]}, {30'h0, c[4], c[0]});
        // Master bit clock at a quarter of mclk, under half
        if (c[4]) chk({31'h0, nb > 0}, {31'h0, clk});
        if (c[4] && !clk) chk({31'h0, b0}, {31'h0, c[6]});
        if (c[0]) chk({31'h0, nf > 0}, {31'h0, fs});
        if (fs) chk({31'h0, hi > 550}, {31'h0, c[2]});
    endtask

    task automatic do_reset(input int cycles);
        logic [31:0] q;
        logic [1:0]  r;
        rst_n <= 1'b0;
        repeat (cycles) @(posedge mclk);
        rst_n <= 1'b1;
        mreg = '{default: 32'h0};
        @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, addrs[i], 32'h0, q, r);
            chk(q, 32'h0);
        end
    endtask

    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        logic [8:0]  cs [10];
        cs = '{9'h010, 9'h090, 9'h030, 9'h070, 9'h081, 9'h181, 9'h103,
               9'h107, 9'h091, 9'h180};
        do_reset(16);
        $display("reset test done");
        put(32'h6010, $random(seed));
        put(32'h600c, $random(seed));
        $display("unmapped test done");
        put(addrs[0], 32'h1);
        xfer(1'b0, 32'h6104, 32'h0, q, r);
        chk(q, 32'h1);
        xfer(1'b1, 32'h6104, 32'h1, q, r);
        chk({30'h0, r}, 32'h0);
        xfer(1'b0, 32'h6104, 32'h0, q, r);
        chk(q, 32'h0);
        put(addrs[4], 32'h0201);
        put(addrs[0], 32'h1);
        put(addrs[2], 32'h00010003);
        put(addrs[0], 32'h00010001);
        put(addrs[4], 32'h1f01);
        $display("refusal test done");
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
                wstrb <= 4'($random(seed));
                put(addrs[i], $random(seed));
            end
        end
        wstrb <= 4'hf;
        $display("random register test done");
        do_reset(4);
        put(addrs[4], 32'h1f01);
        $display("second reset test done");
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 10; k++) pins(p, cs[k]);
        $display("pin role test done");
        give_verdict();
    end
endmodule
`default_nettype wire
